// ==== hw/threshold_alarm_unit.sv ====
// threshold alarm unit: per-axis and system alarms with sticky diagnostic flags
// assumes samples arrive with one-cycle new strobes on the same clock
// Functional notes
// - control bits 0..3 enable the x, y, z and system alarms.
// - control bit 5 high trips system alarm below threshold, else above.
// - control bit 4 selects temperature when high, supply when low.
// - axis alarms have no direction control; only the system alarm does.
// - axis thresholds are full 16-bit two's-complement values.
// - system threshold uses bits 11..0; bits 15..12 are reserved.
// - four sticky flags sit in diagnostic status bits 11..8.
// - control bits 15..6 reserved; all alarm registers reset to zero.
// - each register spans two byte addresses, low byte at even address.
// - axis alarm trips when sample magnitude exceeds threshold either sign.
// - an alarm trip ends pre-event buffering via the post-event trigger.
// - writing clear-status bit clears flags and deasserts the alarm output, unless a trip sets a flag in that same cycle.
`timescale 1ns/1ps
module threshold_alarm_unit
  import alarm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire reg_req_t req,
  input wire sample_t smp,
  output logic [15:0] rd_data,
  output logic alarm_out,
  output logic post_event_trigger
);
  logic [15:0] x_thr_r, x_thr_nxt;
  logic [15:0] y_thr_r, y_thr_nxt;
  logic [15:0] z_thr_r, z_thr_nxt;
  logic [11:0] s_thr_r, s_thr_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [3:0] flags_r, flags_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic alarm_r, alarm_nxt;
  logic trig_r, trig_nxt;
  logic [3:0] trip;
  logic clear;

  // byte write into a 16-bit register: even address low byte, odd high
  function automatic logic [15:0] byte_wr(input logic [15:0] cur, input logic hi,
                                          input logic [7:0] d);
    byte_wr = hi ? {d, cur[7:0]} : {cur[15:8], d};
  endfunction

  function automatic logic hits(input logic [6:0] a, input logic [6:0] base);
    hits = (a[6:1] == base[6:1]);
  endfunction

  // magnitude test; widened to 17 bits so -32768 does not wrap
  function automatic logic exceeds(input logic signed [15:0] s, input logic signed [15:0] t);
    logic signed [16:0] ms;
    logic signed [16:0] mt;
    ms = s[15] ? -{s[15], s} : {s[15], s};
    mt = t[15] ? -{t[15], t} : {t[15], t};
    exceeds = ms > mt;
  endfunction

  // one-hot register select, shared by the write and read decoders
  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_X = 7'b0000010,
    SEL_Y = 7'b0000100,
    SEL_Z = 7'b0001000,
    SEL_S = 7'b0010000,
    SEL_CTRL = 7'b0100000,
    SEL_DIAG = 7'b1000000
  } reg_sel_t;

  // the command register is left out: it is write-only and decoded on its own
  function automatic reg_sel_t decode(input logic [6:0] a);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (hits(a, ADDR_X_THR)) begin
      sel = SEL_X;
    end else if (hits(a, ADDR_Y_THR)) begin
      sel = SEL_Y;
    end else if (hits(a, ADDR_Z_THR)) begin
      sel = SEL_Z;
    end else if (hits(a, ADDR_S_THR)) begin
      sel = SEL_S;
    end else if (hits(a, ADDR_CTRL)) begin
      sel = SEL_CTRL;
    end else if (hits(a, ADDR_DIAG)) begin
      sel = SEL_DIAG;
    end
    decode = sel;
  endfunction

  // one axis alarm: enabled, fresh sample, and the magnitude test
  function automatic logic axis_trip(input logic en, input logic fresh,
                                     input logic signed [15:0] s, input logic signed [15:0] t);
    axis_trip = en & fresh & exceeds(s, t);
  endfunction

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic wr_low;
  logic [11:0] watched;
  logic sys_hit;

  // request decode
  always_comb begin
    wr_sel = SEL_NONE;
    rd_sel = SEL_NONE;
    if (req.wr) begin
      wr_sel = decode(req.addr);
    end
    if (req.rd) begin
      rd_sel = decode(req.addr);
    end
    wr_low = (req.addr[0] == 1'b0);
    clear = req.wr && hits(req.addr, ADDR_GCMD) && wr_low &&
            req.data[GCMD_CLEAR_BIT];
  end

  // x threshold
  always_comb begin
    x_thr_nxt = x_thr_r;
    if (wr_sel == SEL_X) begin
      x_thr_nxt = byte_wr(x_thr_r, req.addr[0], req.data);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      x_thr_r <= REG_RESET;
    end else begin
      x_thr_r <= x_thr_nxt;
    end
  end

  // y threshold
  always_comb begin
    y_thr_nxt = y_thr_r;
    if (wr_sel == SEL_Y) begin
      y_thr_nxt = byte_wr(y_thr_r, req.addr[0], req.data);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      y_thr_r <= REG_RESET;
    end else begin
      y_thr_r <= y_thr_nxt;
    end
  end

  // z threshold
  always_comb begin
    z_thr_nxt = z_thr_r;
    if (wr_sel == SEL_Z) begin
      z_thr_nxt = byte_wr(z_thr_r, req.addr[0], req.data);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      z_thr_r <= REG_RESET;
    end else begin
      z_thr_r <= z_thr_nxt;
    end
  end

  // system threshold: the top nibble is dropped so reads give zero there
  always_comb begin
    logic [15:0] tmp;
    tmp = byte_wr({4'h0, s_thr_r}, req.addr[0], req.data);
    s_thr_nxt = s_thr_r;
    if (wr_sel == SEL_S) begin
      s_thr_nxt = tmp[S_THR_BITS-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_thr_r <= REG_RESET[S_THR_BITS-1:0];
    end else begin
      s_thr_r <= s_thr_nxt;
    end
  end

  // control: the high byte holds only reserved bits, so its writes are ignored
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_sel == SEL_CTRL && wr_low) begin
      ctrl_nxt = req.data[CTRL_USED_BITS-1:0] & CTRL_MASK;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r <= REG_RESET[CTRL_USED_BITS-1:0];
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // comparisons run only in the cycle that carries a new sample
  // a sample equal to its threshold does not trip: every test is strict
  always_comb begin
    watched = ctrl_r[SRC_TEMP_BIT] ? smp.temp : smp.supply;
    if (ctrl_r[POL_BELOW_BIT]) begin
      sys_hit = (watched < s_thr_r);
    end else begin
      sys_hit = (watched > s_thr_r);
    end
    trip = 4'h0;
    trip[EN_X_BIT] = axis_trip(ctrl_r[EN_X_BIT], smp.x_new, smp.x, x_thr_r);
    trip[1] = axis_trip(ctrl_r[1], smp.y_new, smp.y, y_thr_r);
    trip[2] = axis_trip(ctrl_r[2], smp.z_new, smp.z, z_thr_r);
    trip[EN_S_BIT] = ctrl_r[EN_S_BIT] & smp.sys_new & sys_hit;
  end

  // sticky flags
  always_comb begin
    flags_nxt = flags_r;
    if (clear) begin
      flags_nxt = 4'h0;
    end
    // set wins over a clear in the same cycle
    flags_nxt = flags_nxt | trip;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // the alarm follows the flags of the same edge
  always_comb begin
    alarm_nxt = |flags_nxt;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  // trigger pulses once for every cycle that holds a trip
  always_comb begin
    trig_nxt = |trip;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // readback: unmapped addresses read as zero
  // a read sees register values from before a write in the same cycle
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (req.rd) begin
      case (rd_sel)
        SEL_X: begin
          rd_data_nxt = x_thr_r;
        end
        SEL_Y: begin
          rd_data_nxt = y_thr_r;
        end
        SEL_Z: begin
          rd_data_nxt = z_thr_r;
        end
        SEL_S: begin
          rd_data_nxt = {4'h0, s_thr_r};
        end
        SEL_CTRL: begin
          rd_data_nxt = {10'h000, ctrl_r};
        end
        SEL_DIAG: begin
          rd_data_nxt = {4'h0, flags_r, 8'h00};
        end
        default: begin
          rd_data_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign alarm_out = alarm_r;
  assign post_event_trigger = trig_r;
endmodule // threshold_alarm_unit

// ==== hw/alarm_pkg.sv ====
// constants and carrier types for the threshold alarm unit
// assumes byte-wide register writes arrive already decoded from the serial port
package alarm_pkg;
  localparam logic [6:0] ADDR_X_THR = 7'h20;
  localparam logic [6:0] ADDR_Y_THR = 7'h22;
  localparam logic [6:0] ADDR_Z_THR = 7'h24;
  localparam logic [6:0] ADDR_S_THR = 7'h26;
  localparam logic [6:0] ADDR_CTRL = 7'h28;
  localparam logic [6:0] ADDR_DIAG = 7'h3c;
  localparam logic [6:0] ADDR_GCMD = 7'h3e;
  localparam int EN_X_BIT = 0;
  localparam int EN_S_BIT = 3;
  localparam int SRC_TEMP_BIT = 4;
  localparam int POL_BELOW_BIT = 5;
  localparam int CTRL_USED_BITS = 6;
  localparam int S_THR_BITS = 12;
  localparam int DIAG_FLAG_LSB = 8;
  localparam int GCMD_CLEAR_BIT = 4;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [5:0] CTRL_MASK = 6'h3f;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic x_new;
    logic y_new;
    logic z_new;
    logic sys_new;
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
    logic [11:0] temp;
    logic [11:0] supply;
  } sample_t;
endpackage

// ==== verification/threshold_alarm_unit_sva.sv ====
// port checker for the threshold alarm unit
// assumes it is bound to threshold_alarm_unit
`timescale 1ns/1ps
module threshold_alarm_unit_sva
  import alarm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire reg_req_t req,
  input wire sample_t smp,
  input wire logic [15:0] rd_data,
  input wire logic alarm_out,
  input wire logic post_event_trigger
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire nw = !(smp.x_new | smp.y_new | smp.z_new | smp.sys_new);
  wire clr = req.wr && req.addr == ADDR_GCMD && req.data[GCMD_CLEAR_BIT];
  // set wins over clear, so a clear only counts on a quiet cycle
  sequence clr_s; clr && nw; endsequence
  sequence rd_s(a); req.rd && req.addr == a; endsequence
  alarm_stick_a: assert property (alarm_out && !clr |=> alarm_out) else $error("lost");
  alarm_clear_a: assert property (clr_s |=> !alarm_out) else $error("clr");
  trig_flag_a: assert property (post_event_trigger |-> alarm_out) else $error("trg");
  quiet_trig_a: assert property (nw |=> !post_event_trigger) else $error("idle");
  rise_trig_a: assert property ($rose(alarm_out) |-> post_event_trigger) else $error("r");
  rd_hold_a: assert property (!req.rd |=> $stable(rd_data)) else $error("rd");
  ctrl_rsv_a: assert property (rd_s(ADDR_CTRL) |=> rd_data[15:6] == 0) else $error("c");
  sthr_rsv_a: assert property (rd_s(ADDR_S_THR) |=> rd_data[15:12] == 0) else $error("s");
  diag_rsv_a: assert property (rd_s(ADDR_DIAG) |=> rd_data[7:0] == 0) else $error("d");
endmodule // threshold_alarm_unit_sva

// ==== verification/threshold_alarm_unit_tb.sv ====
// self-checking bench for the threshold alarm unit
// drives decoded register bytes and samples directly
`timescale 1ns/1ps
module threshold_alarm_unit_tb;
  import alarm_pkg::*;
  typedef struct packed {
    logic [7:0] c;
    logic [15:0] s;
    logic [15:0] v;
    logic [11:0] t;
    logic [11:0] p;
    logic [3:0] f;
  } row_t;
  logic clock = 0;
  logic reset = 1;
  reg_req_t req = '0;
  sample_t smp = '0;
  logic [15:0] rd_data;
  logic alarm_out;
  logic post_event_trigger;
  int error_cnt = 0;
  int num_checks = 0;
  row_t rows[8] = '{
    '{8'h00, 16'h0b0a, 16'h2000, 12'h000, 12'hfff, 4'h0},
    '{8'h07, 16'h0b0a, 16'h1064, 12'h000, 12'h000, 4'h7},
    '{8'h07, 16'h0b0a, 16'h1063, 12'h000, 12'h000, 4'h0},
    '{8'h05, 16'h0b0a, 16'hef9c, 12'h000, 12'h000, 4'h5},
    '{8'h08, 16'h0b0a, 16'h0000, 12'hfff, 12'hb0b, 4'h8},
    '{8'h38, 16'hf573, 16'h0000, 12'h572, 12'hfff, 4'h8},
    '{8'h38, 16'hf573, 16'h0000, 12'h574, 12'h000, 4'h0},
    '{8'h28, 16'hf573, 16'h0000, 12'h000, 12'h574, 4'h0}};
  threshold_alarm_unit dut (.clock(clock), .reset(reset), .req(req), .smp(smp),
    .rd_data(rd_data), .alarm_out(alarm_out), .post_event_trigger(post_event_trigger));
  initial forever #20 clock = ~clock;
  task chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task w(logic [6:0] a, logic [7:0] d);
    @(posedge clock) req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) req <= '0;
  endtask
  task r(logic [6:0] a, logic [15:0] e);
    @(posedge clock) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) req <= '0;
    @(negedge clock) chk("rd", e, rd_data);
  endtask
  task s(row_t x);
    @(posedge clock) smp <= {4'hf, x.v, x.v, x.v, x.t, x.p};
    @(posedge clock) smp <= '0;
    @(negedge clock) chk("trig", 16'(|x.f), 16'(post_event_trigger));
  endtask
  task results;
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 0;
    r(ADDR_CTRL, REG_RESET);
    r(ADDR_S_THR, REG_RESET);
    for (int i = 32; i < 38; i += 2) begin
      w(7'(i), 8'h63);
      w(7'(i + 1), 8'h10);
    end
    r(7'h21, 16'h1063);
    foreach (rows[i]) begin
      w(ADDR_CTRL, rows[i].c);
      w(ADDR_S_THR, rows[i].s[7:0]);
      w(ADDR_S_THR + 7'h1, rows[i].s[15:8]);
      w(ADDR_GCMD, 8'h10);
      s(rows[i]);
      chk("alarm", 16'(|rows[i].f), 16'(alarm_out));
      r(ADDR_DIAG, {4'h0, rows[i].f, 8'h00});
    end
    // a trip then a calm sample: the flag must survive the calm one
    s('{8'h28, 16'h0, 16'h0, 12'h0, 12'h000, 4'h8});
    s('{8'h28, 16'h0, 16'h0, 12'h0, 12'hfff, 4'h0});
    r(ADDR_DIAG, 16'h0800);
    w(ADDR_CTRL + 7'h1, 8'hff);
    r(ADDR_CTRL, 16'h0028);
    r(ADDR_S_THR, 16'h0573);
    results;
  end
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule // threshold_alarm_unit_tb
bind threshold_alarm_unit threshold_alarm_unit_sva sva (.clock(clock), .reset(reset),
  .req(req), .smp(smp), .rd_data(rd_data), .alarm_out(alarm_out),
  .post_event_trigger(post_event_trigger));
